// ===== fed_exception_detect.sv
`timescale 1ns/1ns
`default_nettype none
module fed_exception_detect (
  // clock and reset
  input wire logic clock_i,
  input wire logic reset_n_i,
  // instruction from the integer pipeline
  input wire logic instr_valid_i,
  output logic instr_ready_o,
  input wire fed_pkg::fed_op_t instr_op_i,
  input wire fed_pkg::fed_fmt_t instr_fmt_i,
  input wire logic cmp_ordered_rel_i,
  input wire logic [63:0] operand_a_i,
  input wire logic [63:0] operand_b_i,
  // datapath result facts
  input wire logic res_inexact_i,
  input wire logic res_overflow_i,
  input wire logic res_tiny_i,
  input wire logic res_sign_i,
  input wire logic res_int_range_i,
  // control bits
  input wire fed_pkg::fed_rmode_t rmode_i,
  input wire logic [4:0] enable_i,
  input wire logic flush_to_zero_ctl_i,
  input wire logic reg_width_mode_i,
  // control register writes
  input wire logic cause_wr_i,
  input wire logic [5:0] cause_wdata_i,
  input wire logic flag_wr_i,
  input wire logic [4:0] flag_wdata_i,
  // report to the integer pipeline
  output logic report_valid_o,
  output logic trap_o,
  output logic dest_we_o,
  output fed_pkg::fed_sel_t result_sel_o,
  output logic [63:0] default_value_o,
  // status
  output logic [5:0] cause_o,
  output logic [4:0] flag_o,
  output logic pending_o,
  output logic [5:0] save_ops_o
);
  import fed_pkg::*;

  fed_cls_if cls_a ();
  fed_cls_if cls_b ();

  fed_state_t state;
  logic take;
  logic is_double;
  logic is_arith;
  logic is_convert;
  logic uses_b;
  logic any_nan_a;
  logic any_nan_b;
  logic bad_format;
  logic opnd_unimpl;
  logic inv_addsub;
  logic inv_muldiv;
  logic inv_sqrt;
  logic inv_compare;
  logic inv_snan;
  logic div_zero;
  logic res_ok;
  logic tiny;
  logic uflow_flush;
  logic uflow_unimpl;
  logic unimpl;
  logic [5:0] next_cause;
  logic next_trap;
  fed_sel_t next_sel;
  logic next_sign;
  logic [63:0] next_value;

  function automatic logic op_arith(input fed_op_t op);
    return op inside {OP_ADD, OP_SUB, OP_MUL, OP_DIV, OP_SQRT, OP_FP_ABSOLUTE, OP_FP_NEGATE};
  endfunction

  function automatic logic op_convert(input fed_op_t op);
    return op inside {OP_CVT_SINGLE, OP_CVT_DOUBLE, OP_CVT_WORD, OP_CVT_LONG};
  endfunction

  assign take = instr_valid_i & instr_ready_o;
  assign is_double = (instr_fmt_i == FMT_DOUBLE);
  assign is_arith = op_arith(instr_op_i);
  assign is_convert = op_convert(instr_op_i);
  assign uses_b = instr_op_i inside {OP_ADD, OP_SUB, OP_MUL, OP_DIV, OP_COMPARE};

  assign cls_a.raw = operand_a_i;
  assign cls_a.is_double = is_double;
  assign cls_b.raw = operand_b_i;
  assign cls_b.is_double = is_double;

  fed_classify u_cls_a (
    .cls(cls_a)
  );

  fed_classify u_cls_b (
    .cls(cls_b)
  );

  // integer source formats carry no float encodings, so nan and denormal tests are gated off
  logic fp_src;
  assign fp_src = ~instr_fmt_i[1];
  assign any_nan_a = fp_src & (cls_a.snan | cls_a.qnan);
  assign any_nan_b = fp_src & uses_b & (cls_b.snan | cls_b.qnan);

  // reserved codes, integer formats on float operations, and same-format conversions
  always_comb
  begin
    bad_format = 1'b0;
    unique case (instr_op_i)
      OP_RSVD_D, OP_RSVD_E, OP_RSVD_F: bad_format = 1'b1;
      OP_CVT_SINGLE: bad_format = (instr_fmt_i == FMT_SINGLE);
      OP_CVT_DOUBLE: bad_format = (instr_fmt_i == FMT_DOUBLE);
      OP_CVT_WORD, OP_CVT_LONG: bad_format = ~fp_src;
      OP_FP_REG_MOVE: bad_format = ~fp_src;
      default: bad_format = ~fp_src;
    endcase
  end

  // compares and moves are exempt; only converts and computations trap here
  assign opnd_unimpl = fp_src & (is_arith | is_convert) &
    (cls_a.denorm | cls_a.qnan | (uses_b & (cls_b.denorm | cls_b.qnan)));

  assign inv_addsub = fp_src & cls_a.inf & cls_b.inf &
    (((instr_op_i == OP_ADD) & (cls_a.sign != cls_b.sign)) |
     ((instr_op_i == OP_SUB) & (cls_a.sign == cls_b.sign)));
  assign inv_muldiv = fp_src &
    (((instr_op_i == OP_MUL) & ((cls_a.zero & cls_b.inf) | (cls_a.inf & cls_b.zero))) |
     ((instr_op_i == OP_DIV) & ((cls_a.zero & cls_b.zero) | (cls_a.inf & cls_b.inf))));
  assign inv_sqrt = fp_src & (instr_op_i == OP_SQRT) & cls_a.sign & ~cls_a.zero & ~any_nan_a;
  assign inv_compare = (instr_op_i == OP_COMPARE) &
    ((cmp_ordered_rel_i & (any_nan_a | any_nan_b)) |
     (fp_src & (cls_a.snan | cls_b.snan)));
  assign inv_snan = fp_src & (is_arith | is_convert) & (cls_a.snan | (uses_b & cls_b.snan));

  assign div_zero = fp_src & (instr_op_i == OP_DIV) & cls_b.zero & ~cls_a.zero & ~cls_a.inf &
    ~any_nan_a;

  // datapath facts only count when the operands themselves raised nothing
  assign res_ok = (is_arith | is_convert) & ~inv_addsub & ~inv_muldiv & ~inv_sqrt & ~inv_snan &
    ~div_zero;
  assign tiny = res_ok & res_tiny_i;
  assign uflow_flush = tiny & ~enable_i[BIT_UNDERFLOW] & ~enable_i[BIT_INEXACT] &
    flush_to_zero_ctl_i;
  assign uflow_unimpl = tiny & ~uflow_flush;

  // an integer conversion out of range goes to software as unimplemented
  assign unimpl = bad_format | opnd_unimpl | uflow_unimpl |
    (res_ok & (instr_op_i inside {OP_CVT_WORD, OP_CVT_LONG}) & res_int_range_i);

  always_comb
  begin
    next_cause = CAUSE_RST;
    if (unimpl)
    begin
      next_cause[BIT_UNIMPL] = 1'b1;
    end
    else
    begin
      next_cause[BIT_INVALID] = inv_addsub | inv_muldiv | inv_sqrt | inv_compare | inv_snan;
      next_cause[BIT_DIVZERO] = div_zero & ~next_cause[BIT_INVALID];
      if (res_ok)
      begin
        next_cause[BIT_OVERFLOW] = res_overflow_i;
        next_cause[BIT_UNDERFLOW] = uflow_flush & res_inexact_i;
        next_cause[BIT_INEXACT] = res_inexact_i | res_overflow_i | uflow_flush;
      end
    end
  end

  // unimplemented has no enable bit; the standard ones trap only when enabled
  assign next_trap = next_cause[BIT_UNIMPL] | (|(next_cause[4:0] & enable_i));

  always_comb
  begin
    next_sel = SEL_DATAPATH;
    next_sign = res_sign_i;
    if (next_trap)
      next_sel = SEL_NONE;
    else if (next_cause[BIT_INVALID])
      next_sel = SEL_QNAN;
    else if (next_cause[BIT_DIVZERO])
    begin
      next_sel = SEL_INF;
      next_sign = cls_a.sign ^ cls_b.sign;
    end
    else if (next_cause[BIT_OVERFLOW])
      next_sel = SEL_OVERFLOW;
    else if (uflow_flush)
      next_sel = SEL_FLUSH;
    else
      next_sel = SEL_DATAPATH;
  end

  fed_default_value u_default (
    .sel_i(next_sel),
    .rmode_i(rmode_i),
    .sign_i(next_sign),
    .is_double_i(is_double),
    .value_o(next_value)
  );

  // a trapped instruction holds the unit until software clears the cause field
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      state <= ST_RUN;
    else if (take && next_trap)
      state <= ST_TRAPPED;
    else if (cause_wr_i && cause_wdata_i == CAUSE_RST)
      state <= ST_RUN;
  end

  assign instr_ready_o = (state == ST_RUN);
  assign pending_o = (state == ST_TRAPPED);

  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      report_valid_o <= 1'b0;
      trap_o <= 1'b0;
      dest_we_o <= 1'b0;
    end
    else
    begin
      report_valid_o <= take;
      trap_o <= take & next_trap;
      dest_we_o <= take & ~next_trap;
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      result_sel_o <= SEL_NONE;
      default_value_o <= VALUE_RST;
    end
    else if (take)
    begin
      result_sel_o <= next_sel;
      default_value_o <= next_value;
    end
  end

  // an instruction report in the same cycle as a software write wins
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      cause_o <= CAUSE_RST;
    else if (take)
      cause_o <= next_cause;
    else if (cause_wr_i)
      cause_o <= cause_wdata_i;
  end

  // flags are sticky; set wins over a software write in the same cycle
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      flag_o <= FLAG_RST;
    else
      flag_o <= (flag_wr_i ? flag_wdata_i : flag_o) |
        ((take && !next_trap) ? next_cause[4:0] & ~enable_i : FLAG_RST);
  end

  assign save_ops_o = reg_width_mode_i ? SAVE_OPS_WIDE : SAVE_OPS_NARROW;

endmodule
`default_nettype wire

// ===== fed_pkg.sv
package fed_pkg;

  // cause bit positions, flags use the low five
  localparam int CAUSE_W = 6;
  localparam int FLAG_W = 5;
  localparam int BIT_INEXACT = 0;
  localparam int BIT_UNDERFLOW = 1;
  localparam int BIT_OVERFLOW = 2;
  localparam int BIT_DIVZERO = 3;
  localparam int BIT_INVALID = 4;
  localparam int BIT_UNIMPL = 5;

  localparam logic [5:0] CAUSE_RST = 6'h00;
  localparam logic [4:0] FLAG_RST = 5'h00;
  localparam logic [63:0] VALUE_RST = 64'h0000_0000_0000_0000;

  // floating-point register save counts
  localparam logic [5:0] SAVE_OPS_NARROW = 6'h10;
  localparam logic [5:0] SAVE_OPS_WIDE = 6'h20;

  // polarity of the top fraction bit that marks a quiet nan
  localparam logic QUIET_POL = 1'b1;

  localparam int SGL_SIGN = 31;
  localparam int DBL_SIGN = 63;
  localparam logic [31:0] SGL_QNAN = 32'h7FC0_0000;
  localparam logic [31:0] SGL_INF = 32'h7F80_0000;
  localparam logic [31:0] SGL_MAX = 32'h7F7F_FFFF;
  localparam logic [31:0] SGL_MIN = 32'h0000_0001;
  localparam logic [63:0] DBL_QNAN = 64'h7FF8_0000_0000_0000;
  localparam logic [63:0] DBL_INF = 64'h7FF0_0000_0000_0000;
  localparam logic [63:0] DBL_MAX = 64'h7FEF_FFFF_FFFF_FFFF;
  localparam logic [63:0] DBL_MIN = 64'h0000_0000_0000_0001;

  typedef enum logic [1:0] {
    RM_NEAREST = 2'b00,
    RM_ZERO = 2'b01,
    RM_UP = 2'b10,
    RM_DOWN = 2'b11
  } fed_rmode_t;

  typedef enum logic [1:0] {
    FMT_SINGLE = 2'b00,
    FMT_DOUBLE = 2'b01,
    FMT_WORD = 2'b10,
    FMT_LONG = 2'b11
  } fed_fmt_t;

  typedef enum logic [3:0] {
    OP_ADD = 4'b0000,
    OP_SUB = 4'b0001,
    OP_MUL = 4'b0010,
    OP_DIV = 4'b0011,
    OP_SQRT = 4'b0100,
    OP_FP_ABSOLUTE = 4'b0101,
    OP_FP_NEGATE = 4'b0110,
    OP_FP_REG_MOVE = 4'b0111,
    OP_CVT_SINGLE = 4'b1000,
    OP_CVT_DOUBLE = 4'b1001,
    OP_CVT_WORD = 4'b1010,
    OP_CVT_LONG = 4'b1011,
    OP_COMPARE = 4'b1100,
    OP_RSVD_D = 4'b1101,
    OP_RSVD_E = 4'b1110,
    OP_RSVD_F = 4'b1111
  } fed_op_t;

  typedef enum logic [2:0] {
    SEL_DATAPATH = 3'b000,
    SEL_QNAN = 3'b001,
    SEL_INF = 3'b010,
    SEL_OVERFLOW = 3'b011,
    SEL_FLUSH = 3'b100,
    SEL_NONE = 3'b101
  } fed_sel_t;

  typedef enum logic {
    ST_RUN = 1'b0,
    ST_TRAPPED = 1'b1
  } fed_state_t;

endpackage

// ===== fed_cls_if.sv
`timescale 1ns/1ns
`default_nettype none
interface fed_cls_if;
  logic [63:0] raw;
  logic is_double;
  logic sign;
  logic zero;
  logic inf;
  logic snan;
  logic qnan;
  logic denorm;
  modport cls (input raw, input is_double, output sign, output zero, output inf, output snan, output qnan,
    output denorm);
  modport user (output raw, output is_double, input sign, input zero, input inf, input snan, input qnan,
    input denorm);
endinterface
`default_nettype wire

// ===== fed_classify.sv
`timescale 1ns/1ns
`default_nettype none
module fed_classify (
  // operand in, class out
  fed_cls_if.cls cls
);
  import fed_pkg::*;

  logic exp_ones;
  logic exp_zero;
  logic frac_nz;
  logic quiet;

  always_comb
  begin
    if (cls.is_double)
    begin
      exp_ones = &cls.raw[62:52];
      exp_zero = ~|cls.raw[62:52];
      frac_nz = |cls.raw[51:0];
      quiet = cls.raw[51];
      cls.sign = cls.raw[DBL_SIGN];
    end
    else
    begin
      exp_ones = &cls.raw[30:23];
      exp_zero = ~|cls.raw[30:23];
      frac_nz = |cls.raw[22:0];
      quiet = cls.raw[22];
      cls.sign = cls.raw[SGL_SIGN];
    end
  end

  assign cls.zero = exp_zero & ~frac_nz;
  assign cls.denorm = exp_zero & frac_nz;
  assign cls.inf = exp_ones & ~frac_nz;
  assign cls.qnan = exp_ones & frac_nz & (quiet == QUIET_POL);
  assign cls.snan = exp_ones & frac_nz & (quiet != QUIET_POL);

endmodule
`default_nettype wire

// ===== fed_default_value.sv
`timescale 1ns/1ns
`default_nettype none
module fed_default_value (
  // selection
  input wire fed_pkg::fed_sel_t sel_i,
  input wire fed_pkg::fed_rmode_t rmode_i,
  input wire logic sign_i,
  input wire logic is_double_i,
  // substitute value, single in the low word
  output logic [63:0] value_o
);
  import fed_pkg::*;

  typedef enum logic [2:0] {
    MAG_ZERO = 3'b000,
    MAG_MIN = 3'b001,
    MAG_MAX = 3'b010,
    MAG_INF = 3'b011,
    MAG_QNAN = 3'b100
  } fed_mag_t;

  fed_mag_t mag;
  logic [63:0] body;

  // magnitude for a quiet nan, a divide-by-zero infinity, an untrapped overflow or a flushed underflow
  always_comb
  begin
    mag = MAG_ZERO;
    unique case (sel_i)
      SEL_QNAN: mag = MAG_QNAN;
      SEL_INF: mag = MAG_INF;
      SEL_OVERFLOW:
      begin
        unique case (rmode_i)
          RM_NEAREST: mag = MAG_INF;
          RM_ZERO: mag = MAG_MAX;
          RM_UP: mag = sign_i ? MAG_MAX : MAG_INF;
          RM_DOWN: mag = sign_i ? MAG_INF : MAG_MAX;
        endcase
      end
      SEL_FLUSH:
      begin
        unique case (rmode_i)
          RM_NEAREST: mag = MAG_ZERO;
          RM_ZERO: mag = MAG_ZERO;
          RM_UP: mag = sign_i ? MAG_ZERO : MAG_MIN;
          RM_DOWN: mag = sign_i ? MAG_MIN : MAG_ZERO;
        endcase
      end
      default: mag = MAG_ZERO;
    endcase
  end

  always_comb
  begin
    body = VALUE_RST;
    unique case (mag)
      MAG_MIN: body = is_double_i ? DBL_MIN : {32'h0000_0000, SGL_MIN};
      MAG_MAX: body = is_double_i ? DBL_MAX : {32'h0000_0000, SGL_MAX};
      MAG_INF: body = is_double_i ? DBL_INF : {32'h0000_0000, SGL_INF};
      MAG_QNAN: body = is_double_i ? DBL_QNAN : {32'h0000_0000, SGL_QNAN};
      default: body = VALUE_RST;
    endcase
    // the quiet nan carries no sign; every other default keeps the intermediate sign
    if (mag != MAG_QNAN && sign_i)
    begin
      if (is_double_i)
        body[DBL_SIGN] = 1'b1;
      else
        body[SGL_SIGN] = 1'b1;
    end
  end

  assign value_o = body;

endmodule
`default_nettype wire

// ===== fed_exception_detect_sva.sv
`timescale 1ns/1ns
`default_nettype none
module fed_exception_detect_sva (
  // clock and reset
  input wire logic clock_i,
  input wire logic reset_n_i,
  // instruction side
  input wire logic instr_valid_i,
  input wire logic instr_ready_o,
  input wire fed_pkg::fed_op_t instr_op_i,
  input wire logic [4:0] enable_i,
  input wire logic reg_width_mode_i,
  input wire logic cause_wr_i,
  input wire logic [5:0] cause_wdata_i,
  // report and status
  input wire logic report_valid_o,
  input wire logic trap_o,
  input wire logic dest_we_o,
  input wire fed_pkg::fed_sel_t result_sel_o,
  input wire logic [5:0] cause_o,
  input wire logic [4:0] flag_o,
  input wire logic pending_o,
  input wire logic [5:0] save_ops_o
);
  import fed_pkg::*;
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!reset_n_i);
  logic taken;
  assign taken = instr_valid_i && instr_ready_o;
  report_timing_a: assert property (taken |=> report_valid_o) else $error("report not one cycle after accept");
  trap_blocks_a: assert property (trap_o |-> pending_o && !instr_ready_o) else $error("trap did not block");
  trap_no_write_a: assert property (trap_o |-> !dest_we_o && result_sel_o == SEL_NONE) else $error("trap wrote");
  unimpl_trap_a: assert property (report_valid_o && cause_o[BIT_UNIMPL] |-> trap_o) else $error("unimpl untrapped");
  ovf_inexact_a: assert property (report_valid_o && cause_o[BIT_OVERFLOW] |-> cause_o[BIT_INEXACT])
    else $error("overflow without inexact");
  // flags only move for untrapped causes; trapped ones leave the flag alone
  untrap_flag_a: assert property (report_valid_o && !trap_o |-> (cause_o[4:0] & $past(enable_i)) == 5'h00
    && (flag_o & cause_o[4:0]) == cause_o[4:0]) else $error("flag not set");
  enabled_trap_a: assert property (report_valid_o && (cause_o[4:0] & $past(enable_i)) != 5'h00 |-> trap_o)
    else $error("enabled cause untrapped");
  save_count_a: assert property (save_ops_o == (reg_width_mode_i ? 6'h20 : 6'h10))
    else $error("save count wrong");
  clear_pending_a: assert property (cause_wr_i && cause_wdata_i == 6'h00 && !taken |=> !pending_o && instr_ready_o
    && cause_o == 6'h00) else $error("cause clear failed");
  reserved_op_a: assert property (taken && instr_op_i >= OP_RSVD_D |=> trap_o && cause_o == 6'h20)
    else $error("reserved op not trapped");
endmodule
bind fed_exception_detect fed_exception_detect_sva fed_exception_detect_sva_i (.clock_i, .reset_n_i, .instr_valid_i,
  .instr_ready_o, .instr_op_i, .enable_i, .reg_width_mode_i, .cause_wr_i, .cause_wdata_i, .report_valid_o, .trap_o,
  .dest_we_o, .result_sel_o, .cause_o, .flag_o, .pending_o, .save_ops_o);
`default_nettype wire

// ===== fed_core_model.sv
`timescale 1ns/1ns
`default_nettype none
module fed_core_model (
  // clock and reset
  input wire logic clock_i,
  input wire logic reset_n_i,
  // bench request and unit answers
  input wire logic issue_i,
  input wire logic ready_i,
  input wire logic trap_i,
  // to the unit
  output logic valid_o,
  output logic cause_wr_o,
  output logic [5:0] cause_wdata_o
);
  // fixed handler delay stands in for state save and restore
  logic [1:0] handler_cnt;
  assign cause_wdata_o = cause_wr_o ? 6'h00 : 6'h3F;
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      valid_o <= 1'b0;
    else if (issue_i)
      valid_o <= 1'b1;
    else if (ready_i)
      valid_o <= 1'b0;
  end
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      handler_cnt <= 2'h0;
      cause_wr_o <= 1'b0;
    end
    else
    begin
      if (trap_i)
        handler_cnt <= 2'h3;
      else if (handler_cnt != 2'h0)
        handler_cnt <= handler_cnt - 2'h1;
      cause_wr_o <= (handler_cnt == 2'h1);
    end
  end
endmodule
`default_nettype wire

// ===== fed_exception_detect_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module fed_exception_detect_tb_top;
  import fed_pkg::*;
  typedef struct {
    fed_op_t op; logic [31:0] a; logic [31:0] b; bit cmp; bit ix; bit ov; bit tn; bit sg; fed_rmode_t rm;
    logic [4:0] en; bit fs; bit trap; bit we; fed_sel_t sel; logic [63:0] val; logic [5:0] cause;
  } fed_row_t;
  localparam logic [31:0] c_one = 32'h3F80_0000;
  localparam logic [31:0] c_mone = 32'hBF80_0000;
  localparam logic [31:0] c_inf = 32'h7F80_0000;
  localparam logic [31:0] c_zero = 32'h0000_0000;
  localparam logic [31:0] c_snan = 32'h7F80_0001;
  localparam logic [31:0] c_qnan = 32'h7FC0_0000;
  fed_row_t rows [23] = '{
    '{OP_ADD,c_one,c_one,0,1,0,0,0,RM_NEAREST,5'h00,0,0,1,SEL_DATAPATH,c_zero,6'h01},
    '{OP_ADD,c_one,c_one,0,1,0,0,0,RM_NEAREST,5'h01,0,1,0,SEL_NONE,c_zero,6'h01},
    '{OP_SUB,c_inf,c_inf,0,0,0,0,0,RM_NEAREST,5'h00,0,0,1,SEL_QNAN,c_qnan,6'h10},
    '{OP_MUL,c_zero,c_inf,0,0,0,0,0,RM_NEAREST,5'h10,0,1,0,SEL_NONE,c_zero,6'h10},
    '{OP_DIV,c_zero,c_zero,0,0,0,0,0,RM_NEAREST,5'h00,0,0,1,SEL_QNAN,c_qnan,6'h10},
    '{OP_SQRT,c_mone,c_zero,0,0,0,0,0,RM_NEAREST,5'h00,0,0,1,SEL_QNAN,c_qnan,6'h10},
    '{OP_FP_ABSOLUTE,c_snan,c_zero,0,0,0,0,0,RM_NEAREST,5'h00,0,0,1,SEL_QNAN,c_qnan,6'h10},
    '{OP_FP_REG_MOVE,c_snan,c_zero,0,0,0,0,0,RM_NEAREST,5'h00,0,0,1,SEL_DATAPATH,c_zero,6'h00},
    '{OP_COMPARE,c_qnan,c_one,1,0,0,0,0,RM_NEAREST,5'h00,0,0,1,SEL_QNAN,c_zero,6'h10},
    '{OP_COMPARE,c_qnan,c_one,0,0,0,0,0,RM_NEAREST,5'h00,0,0,1,SEL_DATAPATH,c_zero,6'h00},
    '{OP_DIV,c_mone,c_zero,0,0,0,0,0,RM_NEAREST,5'h00,0,0,1,SEL_INF,32'hFF80_0000,6'h08},
    '{OP_ADD,c_one,c_one,0,1,1,0,0,RM_NEAREST,5'h00,0,0,1,SEL_OVERFLOW,c_inf,6'h05},
    '{OP_ADD,c_one,c_one,0,1,1,0,1,RM_ZERO,5'h00,0,0,1,SEL_OVERFLOW,32'hFF7F_FFFF,6'h05},
    '{OP_ADD,c_one,c_one,0,1,1,0,1,RM_UP,5'h00,0,0,1,SEL_OVERFLOW,32'hFF7F_FFFF,6'h05},
    '{OP_ADD,c_one,c_one,0,1,1,0,1,RM_DOWN,5'h00,0,0,1,SEL_OVERFLOW,32'hFF80_0000,6'h05},
    '{OP_ADD,c_one,c_one,0,1,1,0,0,RM_NEAREST,5'h04,0,1,0,SEL_NONE,c_zero,6'h05},
    '{OP_MUL,c_one,c_one,0,1,0,1,1,RM_NEAREST,5'h00,1,0,1,SEL_FLUSH,32'h8000_0000,6'h03},
    '{OP_MUL,c_one,c_one,0,1,0,1,0,RM_UP,5'h00,1,0,1,SEL_FLUSH,32'h0000_0001,6'h03},
    '{OP_MUL,c_one,c_one,0,1,0,1,0,RM_NEAREST,5'h00,0,1,0,SEL_NONE,c_zero,6'h20},
    '{OP_CVT_SINGLE,c_one,c_zero,0,0,0,0,0,RM_NEAREST,5'h00,0,1,0,SEL_NONE,c_zero,6'h20},
    '{OP_RSVD_E,c_one,c_one,0,0,0,0,0,RM_NEAREST,5'h00,0,1,0,SEL_NONE,c_zero,6'h20},
    '{OP_FP_NEGATE,c_snan,c_zero,0,0,0,0,0,RM_NEAREST,5'h00,0,0,1,SEL_QNAN,c_qnan,6'h10},
    '{OP_CVT_WORD,c_snan,c_zero,0,0,0,0,0,RM_NEAREST,5'h10,0,1,0,SEL_NONE,c_zero,6'h10}
  };
  logic clock_i = 1'b0;
  logic reset_n_i, instr_valid_i, cmp_ordered_rel_i, res_inexact_i, res_overflow_i, res_tiny_i, res_sign_i;
  logic flush_to_zero_ctl_i, reg_width_mode_i, cause_wr_i, flag_wr_i, issue, res_int_range_i;
  logic instr_ready_o, report_valid_o, trap_o, dest_we_o, pending_o;
  fed_op_t instr_op_i;
  fed_fmt_t instr_fmt_i;
  fed_rmode_t rmode_i;
  fed_sel_t result_sel_o;
  logic [63:0] operand_a_i, operand_b_i, default_value_o;
  logic [4:0] enable_i, flag_wdata_i, flag_o, exp_flag;
  logic [5:0] cause_wdata_i, cause_o, save_ops_o;
  int fail_count = 0;
  int check_count = 0;
  int cycles = 0;
  always #5 clock_i = ~clock_i;
  fed_exception_detect fed_exception_detect_i (.clock_i, .reset_n_i, .instr_valid_i, .instr_ready_o, .instr_op_i,
    .instr_fmt_i, .cmp_ordered_rel_i, .operand_a_i, .operand_b_i, .res_inexact_i, .res_overflow_i,
    .res_tiny_i, .res_sign_i, .res_int_range_i, .rmode_i, .enable_i, .flush_to_zero_ctl_i, .reg_width_mode_i,
    .cause_wr_i, .cause_wdata_i, .flag_wr_i, .flag_wdata_i, .report_valid_o, .trap_o, .dest_we_o, .result_sel_o,
    .default_value_o, .cause_o, .flag_o, .pending_o, .save_ops_o);
  fed_core_model fed_core_model_i (.clock_i, .reset_n_i, .issue_i(issue), .ready_i(instr_ready_o), .trap_i(trap_o),
    .valid_o(instr_valid_i), .cause_wr_o(cause_wr_i), .cause_wdata_o(cause_wdata_i));
  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string m);
    check_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask
  task automatic wait_for(input bit pend);
    int n;
    n = 0;
    do
    begin
      @(posedge clock_i);
      #1;
      n++;
    end
    while ((pend ? pending_o !== 1'b0 : report_valid_o !== 1'b1) && n < 20);
  endtask
  task automatic run(input fed_row_t r, input fed_fmt_t f = FMT_SINGLE, input logic rng = 1'b0);
    @(posedge clock_i);
    instr_op_i <= r.op;
    instr_fmt_i <= f;
    res_int_range_i <= rng;
    operand_a_i <= {32'h0000_0000, r.a};
    operand_b_i <= {32'h0000_0000, r.b};
    {cmp_ordered_rel_i, res_inexact_i, res_overflow_i, res_tiny_i, res_sign_i} <= {r.cmp, r.ix, r.ov, r.tn, r.sg};
    rmode_i <= r.rm;
    enable_i <= r.en;
    flush_to_zero_ctl_i <= r.fs;
    issue <= 1'b1;
    @(posedge clock_i);
    issue <= 1'b0;
    wait_for(1'b0);
    chk(report_valid_o, 1'b1, "report");
    chk(trap_o, r.trap, "trap");
    chk(cause_o, r.cause, "cause");
    // compares set a condition, not a destination value
    if (r.op != OP_COMPARE)
    begin
      chk(dest_we_o, r.we, "dest write");
      chk(result_sel_o, r.sel, "result select");
      if (r.sel inside {SEL_QNAN, SEL_INF, SEL_OVERFLOW, SEL_FLUSH})
        chk(default_value_o, r.val, "default value");
    end
    if (!r.trap)
      exp_flag = exp_flag | r.cause[4:0];
    chk(flag_o, exp_flag, "sticky flags");
    if (r.trap)
    begin
      chk(pending_o & !instr_ready_o, 1'b1, "pending after trap");
      wait_for(1'b1);
      chk({instr_ready_o, cause_o}, 7'h40, "cleared after cause write");
    end
  endtask
  always @(posedge clock_i)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      fail_count++;
      summarize;
    end
  end
  initial
  begin
    {reset_n_i, cmp_ordered_rel_i, res_inexact_i, res_overflow_i, res_tiny_i, res_sign_i, res_int_range_i} = 7'h00;
    {flush_to_zero_ctl_i, reg_width_mode_i, flag_wr_i, issue} = 4'h0;
    {operand_a_i, operand_b_i} = 128'h0;
    {enable_i, flag_wdata_i, exp_flag} = 15'h0000;
    instr_op_i = OP_ADD;
    instr_fmt_i = FMT_SINGLE;
    rmode_i = RM_NEAREST;
    repeat (2) @(posedge clock_i);
    reset_n_i <= 1'b1;
    foreach (rows[i])
    begin
      run(rows[i]);
      $display("row %0d done", i);
    end
    // double overflow default, double denormal operand, integer range and integer source format
    run(fed_row_t'{OP_ADD,c_zero,c_zero,0,1,1,0,1,RM_NEAREST,5'h00,0,0,1,SEL_OVERFLOW,64'hFFF0_0000_0000_0000,6'h05},
      FMT_DOUBLE);
    run(fed_row_t'{OP_ADD,c_one,c_zero,0,0,0,0,0,RM_NEAREST,5'h00,0,1,0,SEL_NONE,c_zero,6'h20},
      FMT_DOUBLE);
    run(fed_row_t'{OP_CVT_WORD,c_one,c_zero,0,0,0,0,0,RM_NEAREST,5'h00,0,1,0,SEL_NONE,c_zero,6'h20},
      FMT_SINGLE, 1'b1);
    run(fed_row_t'{OP_MUL,c_one,c_one,0,0,0,0,0,RM_NEAREST,5'h00,0,1,0,SEL_NONE,c_zero,6'h20},
      FMT_WORD);
    $display("format and range tests done");
    chk(save_ops_o, 6'h10, "narrow save count");
    @(posedge clock_i);
    reg_width_mode_i <= 1'b1;
    reset_n_i <= 1'b0;
    #1;
    chk(save_ops_o, 6'h20, "wide save count");
    chk({instr_ready_o, pending_o, cause_o, flag_o}, 13'h1000, "reset state");
    repeat (2) @(posedge clock_i);
    reset_n_i <= 1'b1;
    flag_wr_i <= 1'b1;
    flag_wdata_i <= 5'h0A;
    @(posedge clock_i);
    flag_wr_i <= 1'b0;
    @(posedge clock_i);
    #1;
    chk(flag_o, 5'h0A, "flag write");
    // a flag write on the edge that takes an untrapped instruction: written value plus the new flag
    exp_flag = 5'h04;
    fork
      run(rows[0]);
      begin
        repeat (2) @(posedge clock_i);
        flag_wr_i <= 1'b1;
        flag_wdata_i <= 5'h04;
        @(posedge clock_i);
        flag_wr_i <= 1'b0;
      end
    join
    $display("reset, save count and flag write done");
    summarize;
  end
endmodule
`default_nettype wire
